// ==== core/smbus_engine_pkg.sv ====
package smbus_engine_pkg;
// Functional notes
// - first byte: address bits 7..1, direction bit 0
// - receiver acks low on SDA; high means nack
// - direction 1 reads, 0 writes
// - write: master sends bytes, expects slave ack
// - read: slave sends bytes, master acks each
// - master ends transfer with a stop
// - master supplies every SCL pulse
// - whoever sends start plus address is master
// - master starts only on a free bus
// - arbitration loser releases, follows as slave
// - master waits for SCL to really rise
// - detect SCL low longer than 25 ms
// - reset communication within 10 ms of timeout
// - both lines high over 50 us: free
// - pending start issued after bus-free timeout
// - exactly one of four modes, reported by status
// - master receiver acks per assert-acknowledge bit
// - slave acks its own address
// - slave acks general call when enabled
// - slave transmitter drives bytes, awaits master ack
// - slave receiver acks per assert-acknowledge bit
// - stop from master ends slave mode
// - interrupt flag set holds SCL low; the code releases SCL for ST_SLV_STOP
// - flag set on each non-idle state, software clears

////////////////////////////////////////////////////////////////////////////////
// timing, in the link clock domain
localparam int LINK_CLK_NS = 80;
localparam int BIT_HALF_NS = 5000;
localparam int HALF_CYCLES = (BIT_HALF_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
localparam int BUS_FREE_NS = 50000;
localparam int FREE_CYCLES = (BUS_FREE_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
localparam int SCL_LOW_TOUT_MS = 25;
localparam int SCL_LOW_TOUT_CYCLES = (SCL_LOW_TOUT_MS * 1000000 + LINK_CLK_NS - 1) / LINK_CLK_NS;
localparam int COMM_RESET_MS = 10;

////////////////////////////////////////////////////////////////////////////////
// byte layout
localparam logic [3:0] BIT_LAST = 4'h7;
localparam logic [3:0] BIT_ACK = 4'h8;
localparam int DIR_BIT = 0;
localparam logic DIR_READ = 1'b1;
localparam int GC_EN_BIT = 0;
localparam logic [6:0] GC_ADDR = 7'h00;

////////////////////////////////////////////////////////////////////////////////
// status codes
localparam logic [7:0] ST_START = 8'h08;
localparam logic [7:0] ST_RSTART = 8'h10;
localparam logic [7:0] ST_ADDR_W_ACK = 8'h18;
localparam logic [7:0] ST_ADDR_W_NACK = 8'h20;
localparam logic [7:0] ST_TX_ACK = 8'h28;
localparam logic [7:0] ST_TX_NACK = 8'h30;
localparam logic [7:0] ST_ARB_LOST = 8'h38;
localparam logic [7:0] ST_ADDR_R_ACK = 8'h40;
localparam logic [7:0] ST_ADDR_R_NACK = 8'h48;
localparam logic [7:0] ST_RX_ACK = 8'h50;
localparam logic [7:0] ST_RX_NACK = 8'h58;
localparam logic [7:0] ST_SLV_W_ADDR = 8'h60;
localparam logic [7:0] ST_GC_W = 8'h70;
localparam logic [7:0] ST_SRX_ACK = 8'h80;
localparam logic [7:0] ST_SRX_NACK = 8'h88;
localparam logic [7:0] ST_SLV_STOP = 8'hA0;
localparam logic [7:0] ST_SLV_R_ADDR = 8'hA8;
localparam logic [7:0] ST_STX_ACK = 8'hB8;
localparam logic [7:0] ST_STX_NACK = 8'hC0;
localparam logic [7:0] ST_IDLE = 8'hF8;

////////////////////////////////////////////////////////////////////////////////
typedef enum logic [1:0] {MODE_MASTER_TX, MODE_MASTER_RX, MODE_SLAVE_TX, MODE_SLAVE_RX} mode_t;
typedef enum {L_IDLE, L_START, L_RSTART, L_LOW, L_HIGH, L_HOLD, L_STOP_LOW, L_STOP_HIGH,
	L_SLAVE, L_SLAVE_HOLD} link_state_t;
typedef struct packed {
	logic enable;
	logic ack_en;
	logic free_tmr_en;
	logic tout_en;
	logic start_req;
	logic stop_req;
} ctrl_t;
typedef struct packed {
	mode_t mode;
	logic [7:0] code;
	logic [7:0] rx_data;
} status_t;
endpackage : smbus_engine_pkg

// ==== core/smbus_master_slave_engine.sv ====
`timescale 1ns/100ps
`default_nettype none
module smbus_master_slave_engine
	import smbus_engine_pkg::*;
#(
	parameter logic [15:0] HALF_CYC = 16'(HALF_CYCLES),
	parameter logic [15:0] FREE_CYC = 16'(FREE_CYCLES),
	parameter logic [19:0] LOW_TOUT_CYC = 20'(SCL_LOW_TOUT_CYCLES)
) (
	// clocks, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic link_clk_in,
	// control
	input wire logic enable_in,
	input wire logic start_in,
	input wire logic stop_set_in,
	input wire logic si_clear_in,
	input wire logic assert_acknowledge_bit_in,
	input wire logic free_timer_en_in,
	input wire logic timeout_en_in,
	input wire logic [7:0] own_address_register_in,
	input wire logic [7:0] tx_data_in,
	// status
	output logic si_out,
	output logic [7:0] state_code_register_out,
	output logic [7:0] rx_data_out,
	output var mode_t mode_out,
	output logic busy_out,
	output logic stop_pending_out,
	output logic scl_timeout_out,
	// open-drain pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);

////////////////////////////////////////////////////////////////////////////////
// core domain
ctrl_t ctrl_r;
logic [7:0] own_q_r, txd_q_r;
logic sto_r, si_r, si_set_r, rel_tgl_r;
status_t stat_r;
logic ev_s1, ev_s2, ev_s3, stp_s1, stp_s2, stp_s3, bsy_s1, bsy_s2, to_s1, to_s2;
// link-domain sources, declared here for the crossings
logic ev_tgl_r, stop_tgl_r, busy_r, tout_r;
status_t ev_stat_r;

wire ev_edge = ev_s2 ^ ev_s3;
wire stop_edge = stp_s2 ^ stp_s3;

always_ff @(posedge core_clk_in) begin
	if (rst_in) begin
		ctrl_r <= '0;
		own_q_r <= 8'h00;
		txd_q_r <= 8'h00;
		sto_r <= 1'b0;
		si_r <= 1'b0;
		si_set_r <= 1'b0;
		rel_tgl_r <= 1'b0;
		stat_r <= '{MODE_SLAVE_RX, ST_IDLE, 8'h00};
		{ev_s1, ev_s2, ev_s3, stp_s1, stp_s2, stp_s3} <= 6'h00;
		{bsy_s1, bsy_s2, to_s1, to_s2} <= 4'h0;
	end else if (ce_in) begin
		{ev_s1, ev_s2, ev_s3} <= {ev_tgl_r, ev_s1, ev_s2};
		{stp_s1, stp_s2, stp_s3} <= {stop_tgl_r, stp_s1, stp_s2};
		{bsy_s1, bsy_s2} <= {busy_r, bsy_s1};
		{to_s1, to_s2} <= {tout_r, to_s1};
		// software sets the stop request, a seen stop clears it; the set wins
		sto_r <= stop_set_in | (sto_r & ~stop_edge);
		ctrl_r <= '{enable_in, assert_acknowledge_bit_in, free_timer_en_in, timeout_en_in, start_in, sto_r};
		own_q_r <= own_address_register_in;
		txd_q_r <= tx_data_in;
		if (ev_edge) begin
			stat_r <= ev_stat_r;
		end
		si_set_r <= ev_edge;
		si_r <= si_set_r | (si_r & ~si_clear_in);
		if (si_clear_in && si_r && !si_set_r) begin
			rel_tgl_r <= ~rel_tgl_r;
		end
	end
end

assign si_out = si_r;
assign state_code_register_out = stat_r.code;
assign rx_data_out = stat_r.rx_data;
assign mode_out = stat_r.mode;
assign busy_out = bsy_s2;
assign stop_pending_out = sto_r;
assign scl_timeout_out = to_s2;

////////////////////////////////////////////////////////////////////////////////
// link domain synchronisers
logic lrst_s1, lrst_s2, ce_s1, ce_s2;
ctrl_t ctl_s1, ctl_s2;
logic rel_s1, rel_s2, rel_s3;
logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;

always_ff @(posedge link_clk_in) begin
	{lrst_s1, lrst_s2} <= {rst_in, lrst_s1};
	{ce_s1, ce_s2} <= {ce_in, ce_s1};
end

always_ff @(posedge link_clk_in) begin
	if (ce_s2) begin
		{ctl_s1, ctl_s2} <= {ctrl_r, ctl_s1};
		{rel_s1, rel_s2, rel_s3} <= {rel_tgl_r, rel_s1, rel_s2};
		{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
		{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
	end
end

////////////////////////////////////////////////////////////////////////////////
// link engine
link_state_t st_r;
logic [15:0] cnt_r, free_cnt_r;
logic [19:0] low_cnt_r;
logic [3:0] bit_r;
logic [7:0] shift_r, own_l_r;
logic master_r, dir_r, addr_ph_r, addressed_r, gc_r, arb_lost_r, ack_r, en_d_r;
logic scl_oe_r, sda_oe_r;

wire en_l = ctl_s2.enable;
wire aa_l = ctl_s2.ack_en;
wire rel_edge = rel_s2 ^ rel_s3;
wire start_det = scl_s2 && scl_d && sda_d && !sda_s2;
wire stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
wire scl_rise = scl_s2 && !scl_d;
wire scl_fall = !scl_s2 && scl_d;
wire slave_st = (st_r == L_SLAVE) || (st_r == L_SLAVE_HOLD);
wire m_rx = master_r && (dir_r == DIR_READ) && !addr_ph_r;
wire m_bit = (bit_r == BIT_ACK) ? (m_rx ? ~aa_l : 1'b1) : (m_rx ? 1'b1 : shift_r[7]);
wire addr_match = shift_r[7:1] == own_l_r[7:1];
wire gc_match = (shift_r[7:1] == GC_ADDR) && own_l_r[GC_EN_BIT];
wire ack_now = !sda_s2;
wire sample_pt = (st_r == L_HIGH) && scl_s2 && (cnt_r == 16'h0000);
wire arb_loss = sample_pt && !sda_oe_r && !sda_s2 && !m_rx && (bit_r != BIT_ACK);
wire tout_hit = ctl_s2.tout_en && !scl_s2 && (low_cnt_r == LOW_TOUT_CYC - 20'h0_0001);
wire free_hit = ctl_s2.free_tmr_en && scl_s2 && sda_s2 && (free_cnt_r == FREE_CYC - 16'h0001);
wire [7:0] m_addr_code = (dir_r == DIR_READ) ? (ack_now ? ST_ADDR_R_ACK : ST_ADDR_R_NACK) :
	(ack_now ? ST_ADDR_W_ACK : ST_ADDR_W_NACK);
wire [7:0] m_data_code = (dir_r == DIR_READ) ? (aa_l ? ST_RX_ACK : ST_RX_NACK) :
	(ack_now ? ST_TX_ACK : ST_TX_NACK);
wire [7:0] m_code = addr_ph_r ? m_addr_code : m_data_code;
wire [7:0] s_addr_code = (dir_r == DIR_READ) ? ST_SLV_R_ADDR : (gc_r ? ST_GC_W : ST_SLV_W_ADDR);
wire [7:0] s_data_code = (dir_r == DIR_READ) ? (ack_r ? ST_STX_ACK : ST_STX_NACK) :
	(sda_oe_r ? ST_SRX_ACK : ST_SRX_NACK);
wire [7:0] s_code = !addressed_r ? ST_ARB_LOST : (addr_ph_r ? s_addr_code : s_data_code);
wire mode_t m_mode = (dir_r == DIR_READ) ? MODE_MASTER_RX : MODE_MASTER_TX;
wire mode_t s_mode = (dir_r == DIR_READ) ? MODE_SLAVE_TX : MODE_SLAVE_RX;

// line watchers: timeouts and bus occupancy
always_ff @(posedge link_clk_in) begin
	if (lrst_s2) begin
		low_cnt_r <= 20'h0_0000;
		free_cnt_r <= 16'h0000;
		busy_r <= 1'b0;
		tout_r <= 1'b0;
		stop_tgl_r <= 1'b0;
	end else if (ce_s2) begin
		low_cnt_r <= (!scl_s2 && ctl_s2.tout_en) ? low_cnt_r + 20'h0_0001 : 20'h0_0000;
		free_cnt_r <= (scl_s2 && sda_s2 && !free_hit) ? free_cnt_r + 16'h0001 : 16'h0000;
		tout_r <= tout_hit | (tout_r & ~scl_s2);
		if (start_det) begin
			busy_r <= 1'b1;
		end else if (stop_det || free_hit) begin
			busy_r <= 1'b0;
		end
		if (stop_det) begin
			stop_tgl_r <= ~stop_tgl_r;
		end
	end
end

// byte, bit and role sequencer
always_ff @(posedge link_clk_in) begin
	if (lrst_s2) begin
		st_r <= L_IDLE;
		cnt_r <= 16'h0000;
		bit_r <= 4'h0;
		shift_r <= 8'h00;
		own_l_r <= 8'h00;
		{master_r, dir_r, addr_ph_r, addressed_r, gc_r, arb_lost_r, ack_r, en_d_r} <= 8'h00;
		scl_oe_r <= 1'b0;
		sda_oe_r <= 1'b0;
		ev_tgl_r <= 1'b0;
		ev_stat_r <= '{MODE_SLAVE_RX, ST_IDLE, 8'h00};
	end else if (ce_s2) begin
		en_d_r <= en_l;
		// address is static configuration, taken when the engine is switched on
		if (en_l && !en_d_r) begin
			own_l_r <= own_q_r;
		end
		if (!en_l || tout_hit) begin
			st_r <= L_IDLE;
			{master_r, addressed_r, arb_lost_r} <= 3'h0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (slave_st && stop_det) begin
			if (addressed_r) begin
				ev_stat_r <= '{s_mode, ST_SLV_STOP, shift_r};
				ev_tgl_r <= ~ev_tgl_r;
			end
			st_r <= L_IDLE;
			addressed_r <= 1'b0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end else if (slave_st && free_hit) begin
			// lines idle long enough: a waiting start may go out
			st_r <= L_IDLE;
			addressed_r <= 1'b0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end else if (st_r == L_SLAVE && start_det) begin
			// the start's own clock fall wraps the count to the first bit
			bit_r <= 4'hf;
			{addr_ph_r, addressed_r, arb_lost_r} <= 3'b100;
			sda_oe_r <= 1'b0;
		end else begin
			unique case (st_r)
				L_IDLE: begin
					scl_oe_r <= 1'b0;
					sda_oe_r <= 1'b0;
					if (start_det) begin
						st_r <= L_SLAVE;
						bit_r <= 4'hf;
						{addr_ph_r, addressed_r, arb_lost_r} <= 3'b100;
					end else if (ctl_s2.start_req && !busy_r) begin
						sda_oe_r <= 1'b1;
						cnt_r <= HALF_CYC;
						st_r <= L_START;
					end
				end
				L_START: begin
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else begin
						ev_stat_r <= '{MODE_MASTER_TX, master_r ? ST_RSTART : ST_START, shift_r};
						ev_tgl_r <= ~ev_tgl_r;
						scl_oe_r <= 1'b1;
						master_r <= 1'b1;
						addr_ph_r <= 1'b1;
						bit_r <= 4'h0;
						st_r <= L_HOLD;
					end
				end
				L_RSTART: begin
					// low half with data released, then a high half before the new start
					if (scl_oe_r) begin
						if (cnt_r != 16'h0000) begin
							cnt_r <= cnt_r - 16'h0001;
						end else begin
							scl_oe_r <= 1'b0;
							cnt_r <= HALF_CYC;
						end
					end else if (scl_s2) begin
						if (cnt_r != 16'h0000) begin
							cnt_r <= cnt_r - 16'h0001;
						end else begin
							sda_oe_r <= 1'b1;
							cnt_r <= HALF_CYC;
							st_r <= L_START;
						end
					end
				end
				L_LOW: begin
					scl_oe_r <= 1'b1;
					sda_oe_r <= ~m_bit;
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else begin
						scl_oe_r <= 1'b0;
						cnt_r <= HALF_CYC;
						st_r <= L_HIGH;
					end
				end
				L_HIGH: begin
					if (!scl_s2) begin
						cnt_r <= HALF_CYC;
					end else if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else if (arb_loss) begin
						shift_r <= {shift_r[6:0], sda_s2};
						master_r <= 1'b0;
						arb_lost_r <= 1'b1;
						sda_oe_r <= 1'b0;
						st_r <= L_SLAVE;
					end else if (bit_r != BIT_ACK) begin
						shift_r <= {shift_r[6:0], sda_s2};
						bit_r <= bit_r + 4'h1;
						cnt_r <= HALF_CYC;
						scl_oe_r <= 1'b1;
						st_r <= L_LOW;
					end else begin
						ev_stat_r <= '{m_mode, m_code, shift_r};
						ev_tgl_r <= ~ev_tgl_r;
						scl_oe_r <= 1'b1;
						st_r <= L_HOLD;
					end
				end
				L_HOLD: begin
					if (rel_edge) begin
						cnt_r <= HALF_CYC;
						if (ctl_s2.stop_req) begin
							sda_oe_r <= 1'b1;
							st_r <= L_STOP_LOW;
						end else if (ctl_s2.start_req) begin
							sda_oe_r <= 1'b0;
							st_r <= L_RSTART;
						end else begin
							if (bit_r == BIT_ACK) begin
								addr_ph_r <= 1'b0;
							end else begin
								dir_r <= txd_q_r[DIR_BIT];
							end
							shift_r <= txd_q_r;
							bit_r <= 4'h0;
							st_r <= L_LOW;
						end
					end
				end
				L_STOP_LOW: begin
					scl_oe_r <= 1'b1;
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else begin
						scl_oe_r <= 1'b0;
						cnt_r <= HALF_CYC;
						st_r <= L_STOP_HIGH;
					end
				end
				L_STOP_HIGH: begin
					if (scl_s2) begin
						if (cnt_r != 16'h0000) begin
							cnt_r <= cnt_r - 16'h0001;
						end else begin
							sda_oe_r <= 1'b0;
							master_r <= 1'b0;
							st_r <= L_IDLE;
						end
					end
				end
				L_SLAVE: begin
					if (scl_rise) begin
						if (bit_r != BIT_ACK) begin
							shift_r <= {shift_r[6:0], sda_s2};
						end else begin
							ack_r <= !sda_s2;
						end
					end else if (scl_fall) begin
						if (bit_r == BIT_LAST) begin
							bit_r <= BIT_ACK;
							if (addr_ph_r) begin
								addressed_r <= (addr_match || gc_match) && aa_l;
								gc_r <= gc_match && !addr_match;
								dir_r <= shift_r[DIR_BIT];
								sda_oe_r <= (addr_match || gc_match) && aa_l;
							end else begin
								sda_oe_r <= addressed_r && (dir_r != DIR_READ) && aa_l;
							end
						end else if (bit_r == BIT_ACK) begin
							bit_r <= 4'h0;
							if (addressed_r || arb_lost_r) begin
								ev_stat_r <= '{s_mode, s_code, shift_r};
								ev_tgl_r <= ~ev_tgl_r;
								scl_oe_r <= 1'b1;
								st_r <= L_SLAVE_HOLD;
							end else begin
								sda_oe_r <= 1'b0;
								addr_ph_r <= 1'b0;
							end
						end else begin
							bit_r <= bit_r + 4'h1;
							if (addressed_r && dir_r == DIR_READ && !addr_ph_r) begin
								sda_oe_r <= ~shift_r[7];
							end else begin
								sda_oe_r <= 1'b0;
							end
						end
					end
				end
				L_SLAVE_HOLD: begin
					if (rel_edge) begin
						arb_lost_r <= 1'b0;
						addr_ph_r <= 1'b0;
						scl_oe_r <= 1'b0;
						st_r <= L_SLAVE;
						// forced stop, or a nack from the reading master, ends the addressing
						if (ctl_s2.stop_req || (dir_r == DIR_READ && !addr_ph_r && !ack_r)) begin
							addressed_r <= 1'b0;
							sda_oe_r <= 1'b0;
						end else if (addressed_r && dir_r == DIR_READ) begin
							shift_r <= txd_q_r;
							sda_oe_r <= ~txd_q_r[7];
						end else begin
							sda_oe_r <= 1'b0;
						end
					end
				end
			endcase
		end
	end
end

assign scl_out = 1'b0;
assign sda_out = 1'b0;
assign scl_oe_out = scl_oe_r;
assign sda_oe_out = sda_oe_r;

////////////////////////////////////////////////////////////////////////////////
// checks
a_si_after_code: assert property (@(posedge core_clk_in) disable iff (rst_in)
	$rose(si_r) |-> $past(ev_edge, 2) && stat_r == $past(stat_r)) else $error("flag rose without a fresh code");
a_si_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in)
	si_r && !si_clear_in && ce_in |=> si_r) else $error("flag dropped without software clear");
a_hold_stretch: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	(st_r == L_HOLD || st_r == L_SLAVE_HOLD) && ce_s2 && !rel_edge |=> scl_oe_r) else $error("clock released in hold");
a_arb_release: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	arb_loss && en_l && ce_s2 && !tout_hit |=> !sda_oe_r && !master_r && st_r == L_SLAVE) else $error("loser kept driving");
a_start_free: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	st_r == L_IDLE ##1 st_r == L_START |-> !$past(busy_r)) else $error("start on a busy bus");
a_addr_ack: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	st_r == L_SLAVE && scl_fall && bit_r == BIT_LAST && addr_ph_r && addr_match && aa_l && en_l && ce_s2 && !stop_det
	&& !start_det && !tout_hit |=> sda_oe_r) else $error("own address not acked");
a_mrx_ack: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	st_r == L_LOW && bit_r == BIT_ACK && m_rx && cnt_r < HALF_CYC |-> sda_oe_r == aa_l) else $error("master ack wrong");
a_timeout_reset: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	tout_hit && ce_s2 |=> st_r == L_IDLE && !scl_oe_r && !sda_oe_r) else $error("no reset after timeout");
a_stop_slave: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	slave_st && stop_det && ce_s2 |=> st_r == L_IDLE && !addressed_r) else $error("slave kept after stop");
a_stretch_wait: assert property (@(posedge link_clk_in) disable iff (lrst_s2)
	st_r == L_HIGH && !scl_s2 && ce_s2 && en_l && !tout_hit |=> st_r == L_HIGH && cnt_r == HALF_CYC) else $error("bit timing ran on");

endmodule : smbus_master_slave_engine
`default_nettype wire

// ==== tb/smbus_peer_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module smbus_peer_model #(
	parameter logic [6:0] PEER_ADDR = 7'h5a
) (
	// link clock
	input wire logic clk_in,
	// bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_out,
	output logic sda_oe_out,
	// control, observation
	input wire logic stretch_in,
	input wire logic hold_in,
	input wire logic [7:0] rd_byte_in,
	output logic [7:0] got_byte_out,
	output logic stop_seen_out
);
	logic s_sda = 1'b0;
	logic s_scl = 1'b0;
	logic m_sda = 1'b0;
	logic m_scl = 1'b0;
	// released lines go to the pull-up level, never hold a stale value
	assign sda_oe_out = s_sda | m_sda;
	assign scl_oe_out = s_scl | m_scl | hold_in;
	task automatic wait_link(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_link
	task automatic after_fall();
		@(negedge scl_in);
		wait_link(1);
	endtask : after_fall
	////////////////////////////////////////////////////////////
	// slave side
	task automatic rx(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge scl_in);
			b[i] = sda_in;
		end
	endtask : rx
	task automatic ack(input logic st);
		after_fall();
		s_sda = 1'b1;
		if (st) begin
			s_scl = 1'b1;
			wait_link(40);
			s_scl = 1'b0;
		end
		after_fall();
		s_sda = 1'b0;
	endtask : ack
	task automatic tx(input logic [7:0] b, output logic nack);
		for (int i = 7; i >= 0; i--) begin
			s_sda = ~b[i];
			after_fall();
		end
		s_sda = 1'b0;
		@(posedge scl_in);
		nack = sda_in;
		after_fall();
	endtask : tx
	task automatic serve();
		logic [7:0] b;
		logic rd;
		logic nack;
		rx(b);
		rd = b[0];
		nack = 1'b0;
		if (b[7:1] === PEER_ADDR) begin
			ack(stretch_in);
			while (!nack) begin
				if (rd) begin
					tx(rd_byte_in, nack);
				end else begin
					rx(b);
					got_byte_out = b;
					ack(1'b0);
				end
			end
		end
		wait (1'b0);
	endtask : serve
	initial begin
		got_byte_out = 8'h00;
		stop_seen_out = 1'b0;
		forever begin
			@(negedge sda_in iff scl_in === 1'b1);
			stop_seen_out = 1'b0;
			fork
				serve();
				@(posedge sda_in iff scl_in === 1'b1);
			join_any
			disable fork;
			s_sda = 1'b0;
			s_scl = 1'b0;
			stop_seen_out = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////
	// master side, called by the bench
	task automatic m_start();
		m_sda = 1'b1;
		wait_link(8);
		m_scl = 1'b1;
		wait_link(8);
	endtask : m_start
	task automatic m_bit(input logic b, output logic r);
		m_sda = ~b;
		wait_link(8);
		m_scl = 1'b0;
		wait (scl_in === 1'b1);
		wait_link(8);
		r = sda_in;
		m_scl = 1'b1;
		wait_link(2);
	endtask : m_bit
	task automatic m_byte(input logic [7:0] b, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) m_bit(b[i], r);
		m_bit(1'b1, nack);
	endtask : m_byte
	task automatic m_rbyte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) m_bit(1'b1, b[i]);
		m_bit(nack, r);
	endtask : m_rbyte
	task automatic m_stop();
		m_sda = 1'b1;
		wait_link(8);
		m_scl = 1'b0;
		wait (scl_in === 1'b1);
		wait_link(8);
		m_sda = 1'b0;
		wait_link(8);
	endtask : m_stop
endmodule : smbus_peer_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import smbus_engine_pkg::*;
	localparam logic [6:0] PEER = 7'h5a;
	logic core_clk_in = 1'b0;
	logic link_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic enable_in = 1'b0;
	logic start_in = 1'b0;
	logic stop_set_in = 1'b0;
	logic si_clear_in = 1'b0;
	logic assert_acknowledge_bit_in = 1'b1;
	logic free_timer_en_in = 1'b1;
	logic timeout_en_in = 1'b1;
	logic [7:0] own_address_register_in = 8'h63;
	logic [7:0] tx_data_in = 8'h00;
	logic si_out, busy_out, stop_pending_out, scl_timeout_out;
	logic scl_in, scl_out, scl_oe_out, sda_in, sda_out, sda_oe_out;
	logic [7:0] state_code_register_out, rx_data_out, rd_byte, p_got, d1, d2;
	mode_t mode_out;
	logic p_scl, p_sda, p_stop, r1, r2;
	logic stretch = 1'b0;
	logic hold = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	assign scl_in = ~(scl_oe_out | p_scl);
	assign sda_in = ~(sda_oe_out | p_sda);
	always #10 core_clk_in = ~core_clk_in;
	initial begin
		#7;
		forever #40 link_clk_in = ~link_clk_in;
	end
	// short counts keep the run brief; expectations follow these values
	smbus_master_slave_engine #(.HALF_CYC(16'h0004), .FREE_CYC(16'h0010), .LOW_TOUT_CYC(20'h0_00c8)) i_dut (.*);
	smbus_peer_model #(.PEER_ADDR(PEER)) i_peer (.clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in),
		.scl_oe_out(p_scl), .sda_oe_out(p_sda), .stretch_in(stretch), .hold_in(hold), .rd_byte_in(rd_byte),
		.got_byte_out(p_got), .stop_seen_out(p_stop));
	////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#2;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_si(input logic [7:0] exp);
		for (int n = 0; n < 20000 && si_out !== 1'b1; n++) tick(1);
		chk({7'h00, si_out}, 8'h01);
		chk(state_code_register_out, exp);
	endtask : wait_si
	// tx data and ack level must settle a cycle before the clear
	task automatic go();
		tick(1);
		si_clear_in = 1'b1;
		tick(1);
		si_clear_in = 1'b0;
	endtask : go
	task automatic dut_addr(input logic [7:0] a, input logic [7:0] exp);
		start_in = 1'b1;
		wait_si(ST_START);
		start_in = 1'b0;
		tx_data_in = a;
		go();
		wait_si(exp);
	endtask : dut_addr
	task automatic dut_stop();
		stop_set_in = 1'b1;
		tick(1);
		stop_set_in = 1'b0;
		go();
		for (int n = 0; n < 3000 && stop_pending_out !== 1'b0; n++) tick(1);
		chk({7'h00, p_stop}, 8'h01);
		tick(100);
	endtask : dut_stop
	task automatic results();
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		n_errors++;
		results();
	end
	initial begin
		rd_byte = 8'h3c;
		repeat (5) @(posedge link_clk_in);
		tick(1);
		rst_in = 1'b0;
		tick(20);
		chk(state_code_register_out, ST_IDLE);
		chk({6'h00, mode_out}, {6'h00, MODE_SLAVE_RX});
		chk({5'h00, si_out, scl_oe_out, sda_oe_out}, 8'h00);
		chk({6'h00, scl_out, sda_out}, 8'h00);
		enable_in = 1'b1;
		tick(20);
		stretch = 1'b1;
		dut_addr({PEER, 1'b0}, ST_ADDR_W_ACK);
		stretch = 1'b0;
		chk({6'h00, mode_out}, {6'h00, MODE_MASTER_TX});
		tx_data_in = 8'ha5;
		go();
		wait_si(ST_TX_ACK);
		chk(p_got, 8'ha5);
		dut_stop();
		dut_addr({7'h11, 1'b0}, ST_ADDR_W_NACK);
		dut_stop();
		dut_addr({PEER, 1'b1}, ST_ADDR_R_ACK);
		go();
		wait_si(ST_RX_ACK);
		chk(rx_data_out, 8'h3c);
		chk({6'h00, mode_out}, {6'h00, MODE_MASTER_RX});
		assert_acknowledge_bit_in = 1'b0;
		go();
		wait_si(ST_RX_NACK);
		dut_stop();
		assert_acknowledge_bit_in = 1'b1;
		fork
			begin
				i_peer.m_start();
				i_peer.m_byte(8'h62, r1);
				i_peer.m_byte(8'h9e, r2);
				i_peer.m_stop();
			end
			begin
				wait_si(ST_SLV_W_ADDR);
				go();
				wait_si(ST_SRX_ACK);
				chk(rx_data_out, 8'h9e);
				go();
				wait_si(ST_SLV_STOP);
				go();
			end
		join
		chk({6'h00, r1, r2}, 8'h00);
		fork
			begin
				i_peer.m_start();
				i_peer.m_byte(8'h00, r1);
				i_peer.m_byte(8'h77, r2);
				i_peer.m_stop();
			end
			begin
				wait_si(ST_GC_W);
				assert_acknowledge_bit_in = 1'b0;
				go();
				wait_si(ST_SRX_NACK);
				go();
			end
		join
		chk({6'h00, r1, r2}, 8'h01);
		tick(200);
		go();
		assert_acknowledge_bit_in = 1'b1;
		fork
			begin
				i_peer.m_start();
				i_peer.m_byte(8'h63, r1);
				i_peer.m_rbyte(1'b0, d1);
				i_peer.m_rbyte(1'b1, d2);
				i_peer.m_stop();
			end
			begin
				wait_si(ST_SLV_R_ADDR);
				tx_data_in = 8'hc3;
				go();
				wait_si(ST_STX_ACK);
				chk({6'h00, mode_out}, {6'h00, MODE_SLAVE_TX});
				tx_data_in = 8'h5a;
				go();
				wait_si(ST_STX_NACK);
				go();
			end
		join
		chk(d1, 8'hc3);
		chk(d2, 8'h5a);
		tick(200);
		i_peer.m_start();
		start_in = 1'b1;
		tick(200);
		chk({6'h00, busy_out, si_out}, 8'h02);
		// lines released without a stop: only the bus-free timeout frees the bus
		i_peer.m_sda = 1'b0;
		tick(20);
		i_peer.m_scl = 1'b0;
		wait_si(ST_START);
		start_in = 1'b0;
		dut_stop();
		hold = 1'b1;
		tick(1000);
		chk({6'h00, scl_timeout_out, scl_oe_out | sda_oe_out}, 8'h02);
		hold = 1'b0;
		tick(100);
		chk({7'h00, scl_timeout_out}, 8'h00);
		results();
	end
endmodule : testbench
`default_nettype wire
